// ### dv/diag_reader.sv
// far-side reader model sweeping response byte indices 3..15
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ns
module diag_reader (
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   output logic [7:0]      rd_index_o
);
   logic [7:0] rd_index_d;
   // next index wraps so both refused and valid bytes are asked for
   always_comb rd_index_d = (rd_index_o == 8'h0f) ? 8'h03 : rd_index_o + 8'h01;
   // index register
   always_ff @(posedge mclk_i) rd_index_o <= reset_i ? 8'h03 : rd_index_d;
endmodule // diag_reader

// ### dv/island_diag_checker.sv
// concurrent checks on the island diagnostic byte block
// assumes one clock mclk_i and synchronous active-high reset_i
`timescale 1ns/1ns
module island_diag_checker
   import island_diag_pkg::*;
(
   input wire logic            mclk_i,
   input wire logic            reset_i,
   input wire logic [15:0]     fw_version_i,
   input wire island_state_e   island_state_i,
   input wire comm_faults_s    comm_faults_i,
   input wire scanner_errors_s scanner_errors_i,
   input wire node_status_s    node_status_i,
   input wire logic [7:0]      rd_index_i,
   input wire logic [7:0]      rd_data_o,
   input wire logic            rd_hit_o,
   input wire logic [7:0]      island_diag_header_o,
   input wire logic [7:0]      firmware_version_low_o,
   input wire logic [7:0]      firmware_version_high_o,
   input wire logic [7:0]      node_status_low_o,
   input wire logic [7:0]      island_state_code_o,
   input wire logic [7:0]      island_comm_faults_o,
   input wire logic [7:0]      scanner_errors_low_o,
   input wire logic [7:0]      scanner_errors_high_o,
   input wire logic [7:0]      node_status_high_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   logic         p_rst;
   node_status_s p_ns;
   logic [11:0]  p_se;
   logic [15:0]  p_fw;
   // inputs as seen one edge back
   always_ff @(posedge mclk_i) begin
      p_rst <= reset_i;
      p_ns  <= node_status_i;
      p_se  <= scanner_errors_i;
      p_fw  <= fw_version_i;
   end
   a_header_fixed: assert property (island_diag_header_o == 8'h09)
      else $error("header byte wrong");
   a_fw_pair: assert property (!p_rst |-> {firmware_version_high_o, firmware_version_low_o}
      == $past(fw_version_i)) else $error("firmware bytes wrong");
   a_node_low: assert property (!p_rst |-> node_status_low_o == {p_ns.ctrl_second_kind,
      MODULE_TYPE, p_ns.cfg_mismatch, 4'h0}) else $error("node status low wrong");
   a_state_stop: assert property (!p_rst && $past(island_state_i) == IS_PREOP_STOP
      |-> island_state_code_o == 8'hc0) else $error("stop state code wrong");
   a_state_addr: assert property (!p_rst && $past(island_state_i) == IS_AUTO_ADDR
      |-> island_state_code_o == 8'h62) else $error("auto-address code wrong");
   a_state_run: assert property (!p_rst && $past(island_state_i) == IS_RUN_PREOP
      |-> island_state_code_o == 8'ha2) else $error("run pre-op code wrong");
   a_fault_byte: assert property (!p_rst |-> island_comm_faults_o == $past(comm_faults_i))
      else $error("fault byte wrong");
   a_scan_bytes: assert property (!p_rst |-> scanner_errors_low_o == p_se[7:0] &&
      scanner_errors_high_o == {3'h0, p_se[11], 1'b0, p_se[10:8]})
      else $error("scanner bytes wrong");
   a_global_any: assert property (!p_rst |-> node_status_high_o[1] == (|p_se))
      else $error("global summary bit wrong");
   a_old_fw_mask: assert property (!p_rst && p_fw[15:8] < 8'h02 |-> node_status_high_o[6:5]
      == 2'b00) else $error("version gated bits wrong");
   a_read_miss: assert property (!p_rst && $past(rd_index_i) > 8'h0e |-> !rd_hit_o &&
      rd_data_o == 8'h00) else $error("read outside block wrong");
   a_read_hit: assert property (!p_rst && $past(rd_index_i) == 8'h0a |-> rd_hit_o &&
      rd_data_o == island_state_code_o) else $error("read of state byte wrong");
endmodule // island_diag_checker
bind island_bus_diagnostic_status island_diag_checker u_chk (.*);

// ### dv/tb_top.sv
// self-checking bench for the island diagnostic byte block
// assumes the package, the design, the checker and the reader model
`timescale 1ns/1ns
module tb_top;
   import island_diag_pkg::*;
   logic mclk_i = 0, reset_i = 1, c_rst = 1, have = 0;
   logic [15:0] fw = 0, c_fw;
   island_state_e st = IS_INIT, c_st;
   comm_faults_s cf = '0, c_cf;
   scanner_errors_s se = '0, c_se;
   node_status_s ns = '0, c_ns;
   logic [7:0] idx, c_idx, rd_data_o;
   logic rd_hit_o;
   logic [71:0] all_b;
   int n_mismatch = 0, checks_done = 0;
   logic [7:0] stc [15] = '{8'h00, 8'h40, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h80, 8'h81,
                            8'h82, 8'h83, 8'ha0, 8'ha1, 8'ha2, 8'hc0};
   // clock
   initial forever #25 mclk_i = ~mclk_i;
   diag_reader u_rd (.mclk_i(mclk_i), .reset_i(reset_i), .rd_index_o(idx));
   island_bus_diagnostic_status dut (.mclk_i(mclk_i), .reset_i(reset_i), .fw_version_i(fw),
      .island_state_i(st), .comm_faults_i(cf), .scanner_errors_i(se), .node_status_i(ns),
      .rd_index_i(idx), .rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o),
      .island_diag_header_o(all_b[7:0]), .firmware_version_low_o(all_b[15:8]),
      .firmware_version_high_o(all_b[23:16]), .node_status_low_o(all_b[31:24]),
      .island_state_code_o(all_b[39:32]), .island_comm_faults_o(all_b[47:40]),
      .scanner_errors_low_o(all_b[55:48]), .scanner_errors_high_o(all_b[63:56]),
      .node_status_high_o(all_b[71:64]));
   // model of the expected byte at a response index
   function automatic logic [7:0] exp_byte(input int i);
      logic v2;
      v2 = c_fw[15:8] >= 8'h02;
      if (c_rst) return (i == 6) ? 8'h09 : 8'h00;
      case (i)
         6: return 8'h09;
         7: return c_fw[7:0];
         8: return c_fw[15:8];
         9: return {c_ns.ctrl_second_kind, MODULE_TYPE, c_ns.cfg_mismatch, 4'h0};
         10: return stc[c_st];
         11: return c_cf;
         12: return c_se[7:0];
         13: return {3'h0, c_se[11], 1'b0, c_se[10:8]};
         14: return {c_ns.local_owns_outputs, c_ns.hot_swapped & v2, c_ns.reflex_configured & v2,
            c_ns.card_invalid, c_ns.cfg_protected, c_ns.fieldbus_fault, |c_se, c_ns.module_failed};
         default: return 8'h00;
      endcase
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // capture what the design samples at each edge
   always @(posedge mclk_i) begin
      {c_rst, c_fw, c_st, c_cf, c_se, c_ns, c_idx} <= {reset_i, fw, st, cf, se, ns, idx};
      have <= 1'b1;
   end
   // compare every output mid-cycle once settled
   always @(negedge mclk_i) if (have) begin
      for (int i = 6; i < 15; i++) check("byte", all_b[(i-6)*8 +: 8], exp_byte(i));
      check("rd_data", rd_data_o, c_rst ? 8'h00 : exp_byte(c_idx));
      check("rd_hit", {7'h0, rd_hit_o}, {7'h0, !c_rst && c_idx inside {[6:14]}});
   end
   // random stimulus with a reset in mid-run
   initial begin
      void'($urandom(32'h3a75));
      repeat (5) @(posedge mclk_i);
      reset_i <= 1'b0;
      for (int n = 0; n < 900; n++) begin
         @(posedge mclk_i);
         fw <= {6'h0, 2'($urandom), 8'($urandom)};
         st <= island_state_e'($urandom_range(14));
         cf <= comm_faults_s'(8'($urandom));
         se <= scanner_errors_s'((n % 4 == 0) ? 12'h000 : 12'($urandom));
         ns <= node_status_s'(9'($urandom));
         reset_i <= (n >= 400 && n < 403);
      end
      @(posedge mclk_i);
      wrap_up();
   end
   // watchdog
   initial begin
      repeat (2000) @(posedge mclk_i);
      n_mismatch++;
      wrap_up();
   end
endmodule // tb_top

// ### logic/island_bus_diagnostic_status.sv
// island-level diagnostic bytes 6..14 of a fieldbus node response
// assumes status inputs synchronous to mclk_i; reader selects a byte index
`timescale 1ns/1ns
module island_bus_diagnostic_status (
   input  wire logic                             mclk_i,
   input  wire logic                             reset_i,
   input  wire logic [15:0]                      fw_version_i,
   input  wire island_diag_pkg::island_state_e   island_state_i,
   input  wire island_diag_pkg::comm_faults_s    comm_faults_i,
   input  wire island_diag_pkg::scanner_errors_s scanner_errors_i,
   input  wire island_diag_pkg::node_status_s    node_status_i,
   input  wire logic [7:0]                       rd_index_i,
   output logic [7:0]                            rd_data_o,
   output logic                                  rd_hit_o,
   output logic [7:0]                            island_diag_header_o,
   output logic [7:0]                            firmware_version_low_o,
   output logic [7:0]                            firmware_version_high_o,
   output logic [7:0]                            node_status_low_o,
   output logic [7:0]                            island_state_code_o,
   output logic [7:0]                            island_comm_faults_o,
   output logic [7:0]                            scanner_errors_low_o,
   output logic [7:0]                            scanner_errors_high_o,
   output logic [7:0]                            node_status_high_o
);
   import island_diag_pkg::*;

   // ----------------------------------------------------------------
   // byte assembly
   // ----------------------------------------------------------------
   logic [7:0] hdr_d, fwl_d, fwh_d, nsl_d, isc_d, icf_d, sel_d, seh_d, nsh_d;
   logic [7:0] hdr_q, fwl_q, fwh_q, nsl_q, isc_q, icf_q, sel_q, seh_q, nsh_q;
   logic [7:0] rd_d,  rd_q;
   logic       hit_d, hit_q;
   logic       fw_v2;

   // header, version and node status low
   always_comb begin
      hdr_d = HEADER_VALUE;
      fwl_d = fw_version_i[7:0];
      fwh_d = fw_version_i[15:8];
      nsl_d = 8'h00;
      nsl_d[NL_MISMATCH]            = node_status_i.cfg_mismatch;
      nsl_d[NL_TYPE_LO+1:NL_TYPE_LO] = MODULE_TYPE;
      nsl_d[NL_CTRL_KIND]           = node_status_i.ctrl_second_kind;
   end

   // island state encoding
   always_comb begin
      case (island_state_i)
         IS_INIT:        isc_d = ST_INIT;
         IS_PREOP_RESET: isc_d = ST_PREOP_RESET;
         IS_PREOP_STOP:  isc_d = ST_PREOP_STOP;
         IS_COMM_RESET:  isc_d = ST_COMM_RESET;
         IS_ID_CHECK:    isc_d = ST_ID_CHECK;
         IS_AUTO_ADDR:   isc_d = ST_AUTO_ADDR;
         IS_BOOT_UP:     isc_d = ST_BOOT_UP;
         IS_IMAGE_SETUP: isc_d = ST_IMAGE_SETUP;
         IS_CFG_MATCH:   isc_d = ST_CFG_MATCH;
         IS_CFG_MINOR:   isc_d = ST_CFG_MINOR;
         IS_CFG_MAND:    isc_d = ST_CFG_MAND;
         IS_CFG_ABORT:   isc_d = ST_CFG_ABORT;
         IS_RUN_MATCH:   isc_d = ST_RUN_MATCH;
         IS_RUN_MINOR:   isc_d = ST_RUN_MINOR;
         IS_RUN_PREOP:   isc_d = ST_RUN_PREOP;
         default:        isc_d = ST_INIT;
      endcase
   end

   // fault flags, scanner errors and node status high
   always_comb begin
      icf_d = comm_faults_i;
      sel_d = scanner_errors_i[7:0];
      seh_d = {3'h0, scanner_errors_i[11], 1'b0,
               scanner_errors_i[10:8]};
      fw_v2 = (fw_version_i[15:8] >= FW_V2_HIGH);
      nsh_d = 8'h00;
      nsh_d[NH_MOD_FAIL]  = node_status_i.module_failed;
      nsh_d[NH_GLOBAL]    = |scanner_errors_i;
      nsh_d[NH_FIELDBUS]  = node_status_i.fieldbus_fault;
      nsh_d[NH_PROTECTED] = node_status_i.cfg_protected;
      nsh_d[NH_CARD_BAD]  = node_status_i.card_invalid;
      nsh_d[NH_REFLEX]    = fw_v2 & node_status_i.reflex_configured;
      nsh_d[NH_HOTSWAP]   = fw_v2 & node_status_i.hot_swapped;
      nsh_d[NH_OUT_OWNER] = node_status_i.local_owns_outputs;
   end

   // ----------------------------------------------------------------
   // byte read port
   // ----------------------------------------------------------------
   // selects the byte being registered this edge, so a read shows the same
   // sample as the byte outputs instead of lagging them by one cycle
   always_comb begin
      hit_d = 1'b1;
      case (rd_index_i)
         POS_HEADER:      rd_d = hdr_d;
         POS_FW_LOW:      rd_d = fwl_d;
         POS_FW_HIGH:     rd_d = fwh_d;
         POS_NODE_LOW:    rd_d = nsl_d;
         POS_STATE_CODE:  rd_d = isc_d;
         POS_COMM_FAULTS: rd_d = icf_d;
         POS_SCAN_LOW:    rd_d = sel_d;
         POS_SCAN_HIGH:   rd_d = seh_d;
         POS_NODE_HIGH:   rd_d = nsh_d;
         default: begin
            rd_d  = RESET_BYTE;             // outside the block reads zero
            hit_d = 1'b0;
         end
      endcase
   end

   // registers all bytes; reset clears everything but the fixed header
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         hdr_q <= HEADER_VALUE;
         fwl_q <= RESET_BYTE;
         fwh_q <= RESET_BYTE;
         nsl_q <= RESET_BYTE;
         isc_q <= ST_INIT;
         icf_q <= RESET_BYTE;
         sel_q <= RESET_BYTE;
         seh_q <= RESET_BYTE;
         nsh_q <= RESET_BYTE;
         rd_q  <= RESET_BYTE;
         hit_q <= 1'b0;
      end else begin
         hdr_q <= hdr_d;
         fwl_q <= fwl_d;
         fwh_q <= fwh_d;
         nsl_q <= nsl_d;
         isc_q <= isc_d;
         icf_q <= icf_d;
         sel_q <= sel_d;
         seh_q <= seh_d;
         nsh_q <= nsh_d;
         rd_q  <= rd_d;
         hit_q <= hit_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rd_data_o               = rd_q;
   assign rd_hit_o                = hit_q;
   assign island_diag_header_o    = hdr_q;
   assign firmware_version_low_o  = fwl_q;
   assign firmware_version_high_o = fwh_q;
   assign node_status_low_o       = nsl_q;
   assign island_state_code_o     = isc_q;
   assign island_comm_faults_o    = icf_q;
   assign scanner_errors_low_o    = sel_q;
   assign scanner_errors_high_o   = seh_q;
   assign node_status_high_o      = nsh_q;
endmodule // island_bus_diagnostic_status

// ### logic/island_diag_pkg.sv
// package for the island-level diagnostic byte block
// assumes one system clock; byte positions are response byte indices
package island_diag_pkg;
   // byte positions in the diagnostics response
   localparam logic [7:0] POS_HEADER      = 8'h06;
   localparam logic [7:0] POS_FW_LOW      = 8'h07;
   localparam logic [7:0] POS_FW_HIGH     = 8'h08;
   localparam logic [7:0] POS_NODE_LOW    = 8'h09;
   localparam logic [7:0] POS_STATE_CODE  = 8'h0a;
   localparam logic [7:0] POS_COMM_FAULTS = 8'h0b;
   localparam logic [7:0] POS_SCAN_LOW    = 8'h0c;
   localparam logic [7:0] POS_SCAN_HIGH   = 8'h0d;
   localparam logic [7:0] POS_NODE_HIGH   = 8'h0e;
   // fixed values
   localparam logic [7:0] HEADER_VALUE    = 8'h09;
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [1:0] MODULE_TYPE     = 2'h1;  // arbitrary neutral value
   localparam logic [7:0] FW_V2_HIGH      = 8'h02;
   // node status low fields
   localparam int NL_MISMATCH  = 4;
   localparam int NL_TYPE_LO   = 5;
   localparam int NL_CTRL_KIND = 7;
   // node status high fields
   localparam int NH_MOD_FAIL  = 0;
   localparam int NH_GLOBAL    = 1;
   localparam int NH_FIELDBUS  = 2;
   localparam int NH_PROTECTED = 3;
   localparam int NH_CARD_BAD  = 4;
   localparam int NH_REFLEX    = 5;
   localparam int NH_HOTSWAP   = 6;
   localparam int NH_OUT_OWNER = 7;
   // reserved position in the high scanner byte
   localparam int SH_RESERVED  = 3;
   // island state codes
   localparam logic [7:0] ST_INIT        = 8'h00;
   localparam logic [7:0] ST_PREOP_RESET = 8'h40;
   localparam logic [7:0] ST_COMM_RESET  = 8'h60;
   localparam logic [7:0] ST_ID_CHECK    = 8'h61;
   localparam logic [7:0] ST_AUTO_ADDR   = 8'h62;
   localparam logic [7:0] ST_BOOT_UP     = 8'h63;
   localparam logic [7:0] ST_IMAGE_SETUP = 8'h64;
   localparam logic [7:0] ST_CFG_MATCH   = 8'h80;
   localparam logic [7:0] ST_CFG_MINOR   = 8'h81;
   localparam logic [7:0] ST_CFG_MAND    = 8'h82;
   localparam logic [7:0] ST_CFG_ABORT   = 8'h83;
   localparam logic [7:0] ST_RUN_MATCH   = 8'ha0;
   localparam logic [7:0] ST_RUN_MINOR   = 8'ha1;
   localparam logic [7:0] ST_RUN_PREOP   = 8'ha2;
   localparam logic [7:0] ST_PREOP_STOP  = 8'hc0;

   // island state selector from the scanner
   typedef enum logic [3:0] {
      IS_INIT, IS_PREOP_RESET, IS_COMM_RESET, IS_ID_CHECK, IS_AUTO_ADDR,
      IS_BOOT_UP, IS_IMAGE_SETUP, IS_CFG_MATCH, IS_CFG_MINOR, IS_CFG_MAND,
      IS_CFG_ABORT, IS_RUN_MATCH, IS_RUN_MINOR, IS_RUN_PREOP, IS_PREOP_STOP
   } island_state_e;

   // communication fault flags, bit 7 down to bit 0
   typedef struct packed {
      logic hi_tx_overrun;   // bit 7
      logic hi_rx_overrun;   // bit 6
      logic lo_tx_overrun;   // bit 5
      logic err_status_rst;  // bit 4
      logic err_warn_level;  // bit 3
      logic bus_off;         // bit 2
      logic module_overrun;  // bit 1
      logic lo_rx_overrun;   // bit 0
   } comm_faults_s;

   // scanner global errors, high byte first in packing
   typedef struct packed {
      logic timeout;         // high bit 4
      logic mod_cfg;         // high bit 2
      logic data_len;        // high bit 1
      logic trigger_proto;   // high bit 0
      logic assignment;      // low bit 7
      logic bus_mgmt;        // low bit 6
      logic out_of_order;    // low bit 5
      logic image_err;       // low bit 4
      logic mand_cfg;        // low bit 3
      logic auto_addr;       // low bit 2
      logic id_misuse;       // low bit 1
      logic fatal_bus;       // low bit 0
   } scanner_errors_s;

   // node-level status inputs
   typedef struct packed {
      logic cfg_mismatch;
      logic ctrl_second_kind;
      logic module_failed;
      logic fieldbus_fault;
      logic cfg_protected;
      logic card_invalid;
      logic reflex_configured;
      logic hot_swapped;
      logic local_owns_outputs;
   } node_status_s;
endpackage
